//--- design/ssrh_cnt.sv
/*
 * ssrh_cnt: wrapping 16-bit event counter with synchronous clear.
 * Assumes its reset is already synchronised by the instantiating block.
 */
`timescale 1ns/10ps
module ssrh_cnt #(
    parameter int W = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clr_in,
    input wire logic inc_in,
    output logic [W-1:0] val_out
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // clear wins so a clear request always leaves zero behind
    always_comb begin
        nxt_cnt = cnt_ff;
        if (clr_in) begin
            nxt_cnt = '0;
        end else if (inc_in) begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign val_out = cnt_ff;
endmodule

//--- design/ssrh_pkg.sv
/*
 * ssrh_pkg: function codes, sub-function codes, exception codes, counter slots,
 * reset values and the byte carriers of the serial slave request handler.
 * Assumes a framer on the same clock that strips the check field and reports errors.
 */
package ssrh_pkg;
    // ==========================================================
    // function and sub-function codes
    localparam logic [7:0] FC_RD_BITS = 8'h01;
    localparam logic [7:0] FC_RD_WORDS = 8'h03;
    localparam logic [7:0] FC_RD_EXC = 8'h07;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_EV_CNT = 8'h0b;
    localparam logic [7:0] FC_EV_LOG = 8'h0c;
    localparam logic [7:0] FC_WR_BITS = 8'h0f;
    localparam logic [7:0] FC_WR_WORDS = 8'h10;
    localparam logic [7:0] FC_RW_WORDS = 8'h17;
    localparam logic [15:0] SUB_RESTART = 16'h0001;
    localparam logic [15:0] SUB_DIAG_REG = 16'h0002;
    localparam logic [15:0] SUB_DELIM = 16'h0003;
    localparam logic [15:0] SUB_LISTEN = 16'h0004;
    localparam logic [15:0] SUB_CLEAR = 16'h000a;
    localparam logic [15:0] SUB_CNT_FIRST = 16'h000b;
    localparam logic [15:0] SUB_CNT_LAST = 16'h0012;
    // ==========================================================
    // exceptions, frame layout, reset values
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] DELIM_RST = 8'h0a;
    localparam logic [7:0] MIN_FRAME = 8'h04;
    localparam logic [7:0] WR_DATA_OFS = 8'h07;
    localparam logic [7:0] RW_DATA_OFS = 8'h0b;
    localparam logic [7:0] LOG_BC = 8'h0a;
    localparam logic [7:0] EV_RX = 8'h80;
    localparam logic [7:0] EV_RX_BCAST = 8'h40;
    localparam logic [7:0] EV_RX_LISTEN = 8'h20;
    localparam int HDR_N = 13;
    localparam int LOG_N = 4;
    // ==========================================================
    // counter slots, in sub-function order from SUB_CNT_FIRST
    localparam int CNT_BUS_MSG = 0;
    localparam int CNT_COMM_ERR = 1;
    localparam int CNT_EXC = 2;
    localparam int CNT_SLV_MSG = 3;
    localparam int CNT_NO_RESP = 4;
    localparam int CNT_NAK = 5;
    localparam int CNT_BUSY = 6;
    localparam int CNT_OVR = 7;
    localparam int CNT_EVENT = 8;
    localparam int NCNT = 9;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic err;
        logic ovr;
    } ssrh_rx_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } ssrh_tx_t;
endpackage

//--- design/ssrh_top.sv
/*
 * ssrh_top: slave request handler; takes framed request bytes, executes them on
 * the internal bit and word areas and streams the answer bytes back.
 * Assumes a framer on sys_clk_in that strips address check fields and marks errors.
 */
// Operation
// R1: serve bit and word multiple reads
// R2: store bit and word multiple writes
// R3: combined request writes before it reads
// R4: out-of-area part gives illegal data address
// R5: read-only failure still performs the write; here a bad read quantity blocks it, only an out-of-area read part does not
// R6: answer exception status and diagnostics
// R7: enter listen-only on forcing sub-function
// R8: replace ascii end delimiter from request
// R9: clear counters and diagnostic register
// R10: count bus messages, errors, exceptions
// R11: count slave messages, no-responses, naks; the nak slot is never incremented here
// R12: count busy answers and overruns; the busy slot is never incremented here
// R13: event counter and event log answers
// R14: unsupported codes get illegal function
// R15: listen-only mutes answers until restart
`timescale 1ns/10ps
module ssrh_top #(
    parameter int BITS = 256,
    parameter int WORDS = 128,
    parameter int MAXB = 64,
    parameter int DBUF = 64
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] slave_addr_in,
    input wire logic [7:0] exc_status_in,
    input wire ssrh_pkg::ssrh_rx_t rx_in,
    input wire logic rsp_ready_in,
    input wire logic [15:0] host_addr_in,
    output ssrh_pkg::ssrh_tx_t rsp_out,
    output logic [15:0] host_word_out,
    output logic host_bit_out,
    output logic listen_only_out,
    output logic [7:0] delim_out,
    output logic busy_out
);
    import ssrh_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_CHECK, S_WR, S_RD, S_SEND} ssrh_st_t;
    localparam int RBW = $clog2(MAXB);
    localparam int DBW = $clog2(DBUF);
    localparam int BAW = $clog2(BITS);
    localparam int WAW = $clog2(WORDS);

    // ==========================================================
    // reset release and storage
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [7:0] rb [MAXB];
    logic [7:0] dbuf [DBUF];
    logic bit_mem [BITS];
    logic [15:0] word_mem [WORDS];
    ssrh_st_t st_ff, nxt_st;
    logic [7:0] rlen_ff, nxt_rlen, hlen_ff, nxt_hlen, tlen_ff, nxt_tlen, sidx_ff, nxt_sidx;
    logic [7:0] base_ff, nxt_base, delim_ff, nxt_delim;
    logic [15:0] idx_ff, nxt_idx, ws_ff, nxt_ws, wq_ff, nxt_wq, rs_ff, nxt_rs, rq_ff, nxt_rq;
    logic [15:0] diag_ff, nxt_diag, host_word_ff, nxt_host_word;
    logic isbit_ff, nxt_isbit, dord_ff, nxt_dord, resp_ff, nxt_resp, listen_ff, nxt_listen;
    logic busy_ff, nxt_busy, host_bit_ff, nxt_host_bit;
    logic [7:0] hd_ff [HDR_N];
    logic [7:0] nxt_hd [HDR_N];
    logic [7:0] log_ff [LOG_N];
    logic [7:0] nxt_log [LOG_N];
    ssrh_tx_t rsp_ff, nxt_rsp;
    logic [NCNT-1:0] cnt_inc;
    logic cnt_clr;
    logic [15:0] cnt_val [NCNT];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ==========================================================
    // request decode, valid while the frame sits in rb
    logic [7:0] fc, exc, ev_byte;
    logic [15:0] sub, dat, ws, wq;
    logic [16:0] rd_need, wr_need, area;
    logic [3:0] cnt_idx;
    logic is_rw, isbit, rd_op, wr_op, sub_ok, legal, bcast, chk, gated, respond;
    logic rd_qbad, wr_qbad, rd_abad, wr_abad, do_wr, do_rd;

    function automatic logic [16:0] need(input logic [15:0] q, input logic b);
        return b ? (({1'b0, q} + 17'h00007) >> 3) : {q, 1'b0};
    endfunction

    assign fc = rb[1];
    assign sub = {rb[2], rb[3]};
    assign dat = {rb[4], rb[5]};
    assign is_rw = fc == FC_RW_WORDS;
    assign isbit = fc == FC_RD_BITS || fc == FC_WR_BITS;
    assign rd_op = fc == FC_RD_BITS || fc == FC_RD_WORDS || is_rw; // R1
    assign wr_op = fc == FC_WR_BITS || fc == FC_WR_WORDS || is_rw; // R2
    assign sub_ok = sub == SUB_RESTART || sub == SUB_DIAG_REG || sub == SUB_DELIM ||
        sub == SUB_LISTEN || sub == SUB_CLEAR || (sub >= SUB_CNT_FIRST && sub <= SUB_CNT_LAST);
    assign legal = rd_op || wr_op || fc == FC_RD_EXC || fc == FC_EV_CNT || fc == FC_EV_LOG ||
        (fc == FC_DIAG && sub_ok); // R6 R13 R14
    assign ws = is_rw ? {rb[6], rb[7]} : sub;
    assign wq = is_rw ? {rb[8], rb[9]} : dat;
    assign rd_need = need(dat, isbit);
    assign wr_need = need(wq, isbit);
    assign area = isbit ? 17'(BITS) : 17'(WORDS);
    assign rd_qbad = rd_op && (dat == 16'h0000 || rd_need > 17'(DBUF));
    assign wr_qbad = wr_op && (wq == 16'h0000 ||
        wr_need + {9'h000, is_rw ? RW_DATA_OFS : WR_DATA_OFS} > {9'h000, rlen_ff});
    assign rd_abad = rd_op && ({1'b0, sub} + {1'b0, dat} > area); // R4
    assign wr_abad = wr_op && ({1'b0, ws} + {1'b0, wq} > area); // R4
    assign exc = !legal ? EXC_FUNC : (rd_qbad || wr_qbad) ? EXC_VALUE :
        (rd_abad || wr_abad) ? EXC_ADDR : EXC_NONE; // R14
    assign bcast = rb[0] == BCAST_ADDR;
    assign chk = st_ff == S_CHECK;
    // in listen-only only the restart request is carried out; other requests still count as slave messages and no-responses and are logged
    assign gated = listen_ff && !(fc == FC_DIAG && sub == SUB_RESTART); // R15
    assign respond = !bcast && !listen_ff && !(fc == FC_DIAG && sub == SUB_LISTEN); // R7 R15
    // an out-of-area read part alone does not stop the write; a bad read quantity does
    assign do_wr = legal && wr_op && !wr_qbad && !wr_abad && !rd_qbad && !gated; // R5
    assign do_rd = exc == EXC_NONE && rd_op && respond;
    assign cnt_idx = 4'(sub - SUB_CNT_FIRST);
    assign ev_byte = EV_RX | (bcast ? EV_RX_BCAST : 8'h00) | (listen_ff ? EV_RX_LISTEN : 8'h00);

    // ==========================================================
    // counters
    always_comb begin
        cnt_inc = '0;
        cnt_inc[CNT_BUS_MSG] = rx_in.valid && rx_in.last && !rx_in.err; // R10
        cnt_inc[CNT_COMM_ERR] = rx_in.valid && rx_in.last && rx_in.err; // R10
        cnt_inc[CNT_EXC] = chk && respond && exc != EXC_NONE; // R10
        cnt_inc[CNT_SLV_MSG] = chk; // R11
        cnt_inc[CNT_NO_RESP] = chk && !respond; // R11
        cnt_inc[CNT_OVR] = rx_in.ovr; // R12
        cnt_inc[CNT_EVENT] = chk && !gated && exc == EXC_NONE && fc != FC_EV_CNT &&
            fc != FC_EV_LOG; // R13
        cnt_clr = chk && !gated && fc == FC_DIAG && sub == SUB_CLEAR; // R9
    end

    // nak and busy never happen here, so their slots only ever read zero
    for (genvar i = 0; i < NCNT; i++) begin : g_cnt
        ssrh_cnt #(.W(16)) u_cnt (
            .clk_in(sys_clk_in),
            .rst_n_in(rst_n),
            .clr_in(cnt_clr),
            .inc_in(cnt_inc[i]),
            .val_out(cnt_val[i])
        ); // R11 R12
    end

    // ==========================================================
    // sequencer
    logic rb_we;
    logic [15:0] wa, ra, woff, roff;
    logic [RBW-1:0] rbi, rbi1;
    logic [DBW-1:0] dbi, dbi1;
    logic [7:0] dofs;

    assign wa = ws_ff + idx_ff;
    assign ra = rs_ff + idx_ff;
    assign woff = isbit_ff ? (idx_ff >> 3) : (idx_ff << 1);
    assign roff = isbit_ff ? (idx_ff >> 3) : (idx_ff << 1);
    assign rbi = RBW'({8'h00, base_ff} + woff);
    assign rbi1 = RBW'(rbi + 1'b1);
    assign dbi = DBW'(roff);
    assign dbi1 = DBW'(dbi + 1'b1);
    assign dofs = sidx_ff - hlen_ff;

    always_comb begin
        nxt_st = st_ff;
        nxt_rlen = rlen_ff;
        nxt_idx = idx_ff;
        nxt_ws = ws_ff;
        nxt_wq = wq_ff;
        nxt_rs = rs_ff;
        nxt_rq = rq_ff;
        nxt_base = base_ff;
        nxt_isbit = isbit_ff;
        nxt_dord = dord_ff;
        nxt_resp = resp_ff;
        nxt_hlen = hlen_ff;
        nxt_tlen = tlen_ff;
        nxt_sidx = sidx_ff;
        nxt_listen = listen_ff;
        nxt_delim = delim_ff;
        nxt_diag = diag_ff;
        nxt_hd = hd_ff;
        nxt_log = log_ff;
        nxt_rsp = rsp_ff;
        rb_we = 1'b0;
        case (st_ff)
            S_IDLE: begin
                if (rx_in.valid) begin
                    rb_we = rlen_ff < 8'(MAXB);
                    nxt_rlen = rb_we ? rlen_ff + 8'h01 : rlen_ff;
                    if (rx_in.last) begin
                        if (!rx_in.err && rlen_ff >= MIN_FRAME - 8'h01 &&
                            (rb[0] == slave_addr_in || rb[0] == BCAST_ADDR)) begin
                            nxt_st = S_CHECK;
                        end else begin
                            nxt_rlen = 8'h00;
                        end
                    end
                end
            end
            S_CHECK: begin
                nxt_rlen = 8'h00;
                nxt_idx = 16'h0000;
                nxt_sidx = 8'h00;
                nxt_ws = ws;
                nxt_wq = wq;
                nxt_rs = sub;
                nxt_rq = dat;
                nxt_base = is_rw ? RW_DATA_OFS : WR_DATA_OFS;
                nxt_isbit = isbit;
                nxt_dord = do_rd;
                nxt_resp = respond;
                nxt_log[0] = ev_byte; // R13
                for (int i = 1; i < LOG_N; i++) begin
                    nxt_log[i] = log_ff[i-1];
                end
                for (int i = 0; i < HDR_N; i++) begin
                    nxt_hd[i] = 8'h00;
                end
                nxt_hd[0] = rb[0];
                nxt_hd[1] = fc;
                nxt_hlen = 8'h06;
                if (exc != EXC_NONE) begin
                    nxt_hd[1] = fc | EXC_FLAG; // R14
                    nxt_hd[2] = exc; // R4 R5
                    nxt_hlen = 8'h03;
                end else begin
                    case (fc)
                        FC_RD_BITS, FC_RD_WORDS, FC_RW_WORDS: begin
                            nxt_hd[2] = rd_need[7:0]; // R1
                            nxt_hlen = 8'h03;
                        end
                        FC_RD_EXC: begin
                            nxt_hd[2] = exc_status_in; // R6
                            nxt_hlen = 8'h03;
                        end
                        FC_DIAG: begin
                            {nxt_hd[2], nxt_hd[3]} = sub;
                            {nxt_hd[4], nxt_hd[5]} = sub == SUB_DIAG_REG ? diag_ff :
                                sub >= SUB_CNT_FIRST ? cnt_val[cnt_idx] : dat; // R6 R10 R11 R12
                        end
                        FC_EV_CNT: begin
                            {nxt_hd[4], nxt_hd[5]} = cnt_val[CNT_EVENT]; // R13
                        end
                        FC_EV_LOG: begin
                            nxt_hd[2] = LOG_BC; // R13
                            {nxt_hd[5], nxt_hd[6]} = cnt_val[CNT_EVENT];
                            {nxt_hd[7], nxt_hd[8]} = cnt_val[CNT_BUS_MSG];
                            for (int i = 0; i < LOG_N; i++) begin
                                nxt_hd[9+i] = log_ff[i];
                            end
                            nxt_hlen = 8'(HDR_N);
                        end
                        default: begin
                            for (int i = 2; i < 6; i++) begin
                                nxt_hd[i] = rb[i]; // R2
                            end
                        end
                    endcase
                end
                nxt_tlen = nxt_hlen + (do_rd ? rd_need[7:0] : 8'h00);
                if (!gated && fc == FC_DIAG && exc == EXC_NONE) begin
                    if (sub == SUB_RESTART) nxt_listen = 1'b0; // R15
                    if (sub == SUB_LISTEN) nxt_listen = 1'b1; // R7
                    if (sub == SUB_DELIM) nxt_delim = dat[15:8]; // R8
                    if (sub == SUB_CLEAR) nxt_diag = 16'h0000; // R9
                end
                if (respond && exc != EXC_NONE) nxt_diag = {8'h00, exc};
                // the write part always runs first, then the read part
                nxt_st = do_wr ? S_WR : do_rd ? S_RD : respond ? S_SEND : S_IDLE; // R3
            end
            S_WR: begin
                nxt_idx = idx_ff + 16'h0001;
                if (idx_ff == wq_ff - 16'h0001) begin
                    nxt_idx = 16'h0000;
                    nxt_st = dord_ff ? S_RD : resp_ff ? S_SEND : S_IDLE; // R3 R5
                end
            end
            S_RD: begin
                nxt_idx = idx_ff + 16'h0001;
                if (idx_ff == rq_ff - 16'h0001) nxt_st = S_SEND;
            end
            S_SEND: begin
                if (!rsp_ff.valid || rsp_ready_in) begin
                    if (sidx_ff < tlen_ff) begin
                        nxt_rsp.valid = 1'b1;
                        nxt_rsp.data = sidx_ff < hlen_ff ? hd_ff[sidx_ff[3:0]] : dbuf[dofs[DBW-1:0]];
                        nxt_rsp.last = sidx_ff == tlen_ff - 8'h01;
                        nxt_sidx = sidx_ff + 8'h01;
                    end else begin
                        nxt_rsp = '0;
                        nxt_st = S_IDLE;
                    end
                end
            end
            default: nxt_st = S_IDLE;
        endcase
        nxt_busy = nxt_st != S_IDLE;
        nxt_host_word = word_mem[WAW'(host_addr_in)];
        nxt_host_bit = bit_mem[BAW'(host_addr_in)];
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= S_IDLE;
            {rlen_ff, hlen_ff, tlen_ff, sidx_ff, base_ff} <= '0;
            {idx_ff, ws_ff, wq_ff, rs_ff, rq_ff, diag_ff, host_word_ff} <= '0;
            {isbit_ff, dord_ff, resp_ff, listen_ff, busy_ff, host_bit_ff} <= '0;
            delim_ff <= DELIM_RST;
            hd_ff <= '{default: 8'h00};
            log_ff <= '{default: 8'h00};
            rsp_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            {rlen_ff, hlen_ff, tlen_ff, sidx_ff, base_ff} <=
                {nxt_rlen, nxt_hlen, nxt_tlen, nxt_sidx, nxt_base};
            {idx_ff, ws_ff, wq_ff, rs_ff, rq_ff, diag_ff, host_word_ff} <=
                {nxt_idx, nxt_ws, nxt_wq, nxt_rs, nxt_rq, nxt_diag, nxt_host_word};
            {isbit_ff, dord_ff, resp_ff, listen_ff, busy_ff, host_bit_ff} <=
                {nxt_isbit, nxt_dord, nxt_resp, nxt_listen, nxt_busy, nxt_host_bit};
            delim_ff <= nxt_delim;
            hd_ff <= nxt_hd;
            log_ff <= nxt_log;
            rsp_ff <= nxt_rsp;
        end
    end

    // ==========================================================
    // storage writes; no reset, contents are data only
    always_ff @(posedge sys_clk_in) begin
        if (rb_we) rb[rlen_ff[RBW-1:0]] <= rx_in.data;
        if (st_ff == S_WR && isbit_ff) bit_mem[BAW'(wa)] <= rb[rbi][idx_ff[2:0]]; // R2
        if (st_ff == S_WR && !isbit_ff) word_mem[WAW'(wa)] <= {rb[rbi], rb[rbi1]}; // R2
        if (chk) begin
            for (int i = 0; i < DBUF; i++) dbuf[i] <= 8'h00;
        end
        if (st_ff == S_RD && isbit_ff) dbuf[dbi][idx_ff[2:0]] <= bit_mem[BAW'(ra)]; // R1
        if (st_ff == S_RD && !isbit_ff) begin
            dbuf[dbi] <= word_mem[WAW'(ra)][15:8]; // R1
            dbuf[dbi1] <= word_mem[WAW'(ra)][7:0];
        end
    end

    assign rsp_out = rsp_ff;
    assign host_word_out = host_word_ff;
    assign host_bit_out = host_bit_ff;
    assign listen_only_out = listen_ff;
    assign delim_out = delim_ff;
    assign busy_out = busy_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);

    property p_mute;
        listen_ff |-> !rsp_ff.valid;
    endproperty
    a_mute: assert property (p_mute) // R15
        else $error("answer sent in listen-only mode");
    property p_listen;
        chk && fc == FC_DIAG && sub == SUB_LISTEN |=> listen_ff && st_ff == S_IDLE;
    endproperty
    a_listen: assert property (p_listen) // R7
        else $error("listen-only not entered");
    property p_delim;
        chk && !listen_ff && fc == FC_DIAG && sub == SUB_DELIM |=> delim_ff == $past(rb[4]);
    endproperty
    a_delim: assert property (p_delim) // R8
        else $error("delimiter not replaced");
    property p_clear;
        cnt_clr |=> cnt_val[CNT_COMM_ERR] == 16'h0000 && diag_ff == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) // R9
        else $error("counters not cleared");
    property p_bus_cnt;
        rx_in.valid && rx_in.last && !rx_in.err && !cnt_clr
            |=> cnt_val[CNT_BUS_MSG] == $past(cnt_val[CNT_BUS_MSG]) + 16'h0001;
    endproperty
    a_bus_cnt: assert property (p_bus_cnt) // R10
        else $error("bus message count missed");
    property p_illegal;
        chk && !legal && respond |=> hd_ff[1] == (fc | EXC_FLAG) && hd_ff[2] == EXC_FUNC;
    endproperty
    a_illegal: assert property (p_illegal) // R14
        else $error("unsupported code not refused");
    property p_rd_fail;
        chk && is_rw && !listen_ff && !wr_abad && !wr_qbad && !rd_qbad && rd_abad
            |=> st_ff == S_WR && hd_ff[2] == EXC_ADDR;
    endproperty
    a_rd_fail: assert property (p_rd_fail) // R5
        else $error("write skipped on read-only failure");
    property p_wr_bad;
        chk && wr_op && wr_abad |=> st_ff != S_WR ##0 (st_ff == S_SEND || st_ff == S_IDLE);
    endproperty
    a_wr_bad: assert property (p_wr_bad) // R4
        else $error("out-of-area write performed");
    property p_order;
        st_ff == S_RD && $past(st_ff) != S_RD && fc == FC_RW_WORDS |-> $past(st_ff) == S_WR;
    endproperty
    a_order: assert property (p_order) // R3
        else $error("read before write");
endmodule

//--- verification/serial_slave_request_handler_tb_top.sv
/*
 * serial_slave_request_handler_tb_top: table of requests and answers, then hand tests.
 * Assumes slave address 8'h11 and exception status byte 8'h5a.
 */
`timescale 1ns/10ps
module serial_slave_request_handler_tb_top;
    import ssrh_pkg::*;
    logic sys_clk_in;
    logic rstn_in;
    logic [15:0] host_addr;
    ssrh_rx_t rx;
    ssrh_tx_t rsp;
    logic rdy;
    logic [15:0] host_word;
    logic host_bit;
    logic listen;
    logic busy;
    logic [7:0] delim;
    int n_mismatch;
    int n_tests;
    logic [7:0] got[$];
    logic [7:0] req[$];
    logic [7:0] exq[$];
    string tab[15][2] = '{'{"1110000000020412345678", "111000000002"},
        '{"110300000002", "11030412345678"}, '{"110f000000030105", "110f00000003"},
        '{"110100000003", "11010105"}, '{"1117000000010000000102abcd", "111702abcd"},
        '{"111700ff000100010001021111", "119702"}, '{"11070000", "11075a"},
        '{"110800020000", "110800020002"}, '{"110300000000", "118303"},
        '{"112b0000", "11ab01"}, '{"110800050000", "118801"},
        '{"1103007f0002", "118302"}, '{"1110007f000204aaaabbbb", "119002"},
        '{"110800033a00", "110800033a00"},
        '{"1108000a0000", "1108000a0000"}};
    ssrh_top i_dut(.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .slave_addr_in(8'h11),
        .exc_status_in(8'h5a), .rx_in(rx), .rsp_ready_in(rdy), .host_addr_in(host_addr),
        .rsp_out(rsp), .host_word_out(host_word), .host_bit_out(host_bit),
        .listen_only_out(listen), .delim_out(delim), .busy_out(busy));
    ssrh_master_model i_mst(.clk_in(sys_clk_in), .busy_in(busy), .rsp_in(rsp),
        .rx_out(rx), .ready_out(rdy));
    // ==========================================================
    // clock, checks and frames
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic void hex(input string s, output logic [7:0] q[$]);
        int v;
        q = {};
        for (int i = 0; i + 1 < s.len(); i += 2) begin
            void'($sscanf(s.substr(i, i + 1), "%h", v));
            q.push_back(v[7:0]);
        end
    endfunction
    task automatic run(input string rq, input string ex, input logic e = 1'b0);
        hex(rq, req);
        hex(ex, exq);
        i_mst.xfer(req, e, got);
        chk(16'(got.size()), 16'(exq.size()));
        chk(16'(i_mst.last_at), 16'(exq.size()));
        foreach (exq[i]) chk({8'h00, got[i]}, {8'h00, exq[i]});
    endtask
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    // ==========================================================
    // main sequence
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        host_addr = 16'h0000;
        rstn_in = 1'b0;
        repeat (6) @(negedge sys_clk_in);
        chk({8'h00, delim}, {8'h00, DELIM_RST});
        chk({busy, listen, rsp.valid}, 16'h0000);
        rstn_in = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        for (int i = 0; i < 15; i++) run(tab[i][0], tab[i][1]);
        run("110800020000", "110800020000");
        chk({8'h00, delim}, 16'h003a);
        host_addr = 16'h0001;
        repeat (2) @(negedge sys_clk_in);
        chk(host_word, 16'h1111);
        host_addr = 16'h0000;
        repeat (2) @(negedge sys_clk_in);
        chk(host_word, 16'habcd);
        chk({15'h0000, host_bit}, 16'h0001);
        run("110300000001", "", 1'b1);
        run("1108000c0000", "1108000c0001");
        i_mst.pulse_ovr();
        run("110800120000", "110800120001");
        run("110800040000", "");
        chk({15'h0000, listen}, 16'h0001);
        run("110300000001", "");
        run("110800010000", "");
        chk({15'h0000, listen}, 16'h0000);
        run("110c0000", "110c0a000000050007a0a08080");
        run("110300000001", "110302abcd");
        run("1108000b0000", "1108000b0009");
        run("1108000f0000", "1108000f0003");
        run("1108000e0000", "1108000e000a");
        run("110b0000", "110b00000009");
        tally_and_finish();
    end
endmodule

//--- verification/ssrh_master_model.sv
/*
 * ssrh_master_model: serial master that sends request frames and takes answers.
 * Assumes the handler on clk_in; all changes land on the falling edge.
 */
`timescale 1ns/10ps
module ssrh_master_model
    import ssrh_pkg::*;
(
    input wire logic clk_in,
    input wire logic busy_in,
    input wire ssrh_pkg::ssrh_tx_t rsp_in,
    output ssrh_pkg::ssrh_rx_t rx_out,
    output logic ready_out
);
    // ==========================================================
    // frame and answer transfer
    int last_at;
    initial begin
        rx_out = '0;
        ready_out = 1'b0;
    end
    task automatic xfer(input logic [7:0] q[$], input logic e, output logic [7:0] r[$]);
        int n;
        bit l;
        r = {};
        last_at = 0;
        n = 0;
        foreach (q[i]) begin
            l = (i == q.size() - 1);
            @(negedge clk_in);
            rx_out <= '{1'b1, q[i], l, e & l, 1'b0};
        end
        @(negedge clk_in);
        // idle data shows the inverse so a stale byte cannot pass
        rx_out <= '{1'b0, ~q[q.size() - 1], 1'b0, 1'b0, 1'b0};
        @(negedge clk_in);
        while (n < 400 && busy_in === 1'b1) begin
            // stalls every third cycle to exercise the hold of rsp
            ready_out = (n % 3) != 0;
            if (rsp_in.valid === 1'b1 && ready_out) begin
                r.push_back(rsp_in.data);
                // position sum: a stray or missing last flag cannot match the count
                if (rsp_in.last === 1'b1) last_at += r.size();
            end
            n++;
            @(negedge clk_in);
        end
        ready_out = 1'b0;
    endtask
    task automatic pulse_ovr();
        @(negedge clk_in);
        rx_out.ovr <= 1'b1;
        @(negedge clk_in);
        rx_out.ovr <= 1'b0;
    endtask
endmodule
